// ---- shared/scg_cfg.svh ----
// Purpose: constants of the system clock generator
// Assumes: 100 MHz aclk, AXI4-Lite register access
// Notes: definitions only
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH

// bus clock period and derived timing
`define SCG_CLK_PERIOD_NS 10
`define SCG_FREERUN_NS 500000
`define SCG_LOCK_NS 2000000
`define SCG_FREERUN_CYC (`SCG_FREERUN_NS / `SCG_CLK_PERIOD_NS)
`define SCG_LOCK_CYC (`SCG_LOCK_NS / `SCG_CLK_PERIOD_NS)
`define SCG_TMR_W 18
// watchdog overflow in free-running clocks
`define SCG_WD_LIMIT 5'h10
`define SCG_WD_W 5

// strap patterns
`define SCG_STRAP_X4 3'h7
`define SCG_STRAP_X2 3'h6
`define SCG_STRAP_X3 3'h5
`define SCG_STRAP_X5 3'h4
`define SCG_STRAP_DIRECT 3'h3
`define SCG_STRAP_X1P5 3'h2
`define SCG_STRAP_PRESC 3'h1
`define SCG_STRAP_X2P5 3'h0

// multiply factors expressed in halves
`define SCG_HALVES_X4 4'h8
`define SCG_HALVES_X2 4'h4
`define SCG_HALVES_X3 4'h6
`define SCG_HALVES_X5 4'hA
`define SCG_HALVES_X1P5 4'h3
`define SCG_HALVES_X2P5 4'h5
`define SCG_HALVES_NONE 4'h0

// register map, byte addresses
`define SCG_ADDR_W 4
`define SCG_OFS_STATUS 4'h0
`define SCG_OFS_MASK 4'h4
`define SCG_OFS_INFO 4'h8
// status and mask fields
`define SCG_BIT_LOCK_LOSS 0
`define SCG_BIT_OSC_FAIL 1
`define SCG_IRQ_W 2
`define SCG_MASK_RST 2'h0
// info fields
`define SCG_INFO_STRAP_LSB 0
`define SCG_INFO_LOCKED 3
`define SCG_INFO_FALLBACK 4
`define SCG_INFO_STARTED 5
// bus responses
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2

`endif

// ---- shared/scg_pkg.sv ----
// Purpose: types of the system clock generator
// Assumes: constants come from scg_cfg.svh
// Notes: no constants held here
package scg_pkg;
   // clock source modes chosen by the straps
   typedef enum logic [1:0] {
      SCG_MODE_PLL,
      SCG_MODE_DIRECT,
      SCG_MODE_PRESC
   } scg_mode_t;
endpackage

// ---- src/scg_sync.sv ----
// Purpose: two-flop synchroniser, one per bit
// Assumes: inputs are asynchronous to clk
// Notes: no reset so straps can be seen during reset
`timescale 1ns/1ps
`default_nettype none
module scg_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   genvar i;
   // each bit gets its own pair; first stage feeds only the second
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         always_ff @(posedge clk) begin
            meta_r <= d[i];
            q[i] <= meta_r;
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- src/scg_osc_watchdog.sv ----
// Purpose: oscillator watchdog clocked by free-running pll edges
// Assumes: edge strobes are one-cycle pulses on clk
// Notes: failure latches until reset
`include "scg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scg_osc_watchdog (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic freerun_tick,
   input wire logic osc_edge,
   output logic fail_r
);
   logic [`SCG_WD_W-1:0] cnt_r; // free-running clocks since osc edge

   // count up on pll ticks, clear on any oscillator transition
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (!enable || osc_edge) begin
         cnt_r <= '0;
      end else if (freerun_tick && cnt_r != `SCG_WD_LIMIT) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // overflow is sticky; only reset brings the oscillator back
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fail_r <= 1'b0;
      end else if (enable && cnt_r == `SCG_WD_LIMIT) begin
         fail_r <= 1'b1;
      end
   end

   AST_WD_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
      fail_r |=> fail_r)
      else $error("watchdog failure dropped before reset");
endmodule
`default_nettype wire

// ---- src/scg_top.sv ----
// Purpose: cpu clock source selection, pll supervision, interrupts
// Assumes: pll core outside gives multiplied clock, free-run clock, lock
// Notes: all clocks are resampled on aclk, so aclk must be much faster
//
// Contract
// - straps latched in reset, pll unless bypass
// - 111/110/101/100 give x4/x2/x3/x5
// - 010/000 give x1.5/x2.5 through pll
// - 011 drives cpu clock from oscillator
// - 001 divides oscillator by two
// - prescaler phases last one oscillator period
// - direct phases copy oscillator phases
// - free-running clock settled after half millisecond
// - lock expected within two milliseconds
// - short-term jitter stays below five percent
// - lock loss flags, falls to free-run
// - lock loss flag re-raised while unstable
// - bypass modes run watchdog on free-run clock
// - watchdog counts pll clocks, cleared by edges
// - sixteen clocks idle: switch, flag failure
// - failover holds until hardware reset
`include "scg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scg_top #(
   parameter int P_FREERUN_CYC = `SCG_FREERUN_CYC,
   parameter int P_LOCK_CYC = `SCG_LOCK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   // pins and pll core
   input wire logic [2:0] clock_config_straps,
   input wire logic osc_input_pin,
   input wire logic pll_mult_clk,
   input wire logic pll_freerun_clk,
   input wire logic pll_lock_valid,
   output logic cpu_clk_r,
   output logic pll_enable_r,
   output logic [3:0] pll_mult_halves_r,
   output logic fallback_active_r,
   output logic irq_r,
   // axi4-lite slave
   input wire logic [`SCG_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`SCG_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam logic [`SCG_TMR_W-1:0] FREERUN_CYC = `SCG_TMR_W'(P_FREERUN_CYC);
   localparam logic [`SCG_TMR_W-1:0] LOCK_CYC = `SCG_TMR_W'(P_LOCK_CYC);
   logic [2:0] strap_s; // synchronised strap pins
   logic osc_s, mult_s, free_s, lock_s; // synchronised clocks and lock
   logic osc_d_r, free_d_r; // previous oscillator and free-run samples
   logic [2:0] straps_r; // latched configuration
   scg_pkg::scg_mode_t mode; // decoded mode
   logic [3:0] halves; // decoded multiply factor
   logic osc_edge, osc_rise, free_tick; // edges of the resampled clocks
   logic presc_r; // divide-by-two phase
   logic started_r; // free-run settle time passed
   logic [`SCG_TMR_W-1:0] start_cnt_r; // settle timer
   logic [`SCG_TMR_W-1:0] lock_cnt_r; // lock wait timer
   logic lock_late_r, was_locked_r; // lock overdue, lock seen since start
   logic wd_fail_r; // oscillator watchdog tripped
   logic lock_loss_evt; // lock loss event this cycle
   logic [`SCG_IRQ_W-1:0] status_r; // sticky interrupt status
   logic [`SCG_IRQ_W-1:0] status_set, status_clr; // sets, read clears
   logic [`SCG_IRQ_W-1:0] mask_r; // interrupt enables
   logic aw_got_r, w_got_r; // write address and data held
   logic [`SCG_ADDR_W-1:0] awaddr_r; // held write address
   logic [31:0] wdata_r; // held write data
   logic [3:0] wstrb_r; // held byte enables
   logic aw_hs, w_hs, b_hs, ar_hs, r_hs, wr_do; // handshakes, commit
   // pin inputs cross into aclk through two flops
   scg_sync #(.W(3)) u_sync_strap (
      .clk(aclk),
      .d(clock_config_straps),
      .q(strap_s)
   );
   scg_sync #(.W(4)) u_sync_clk (
      .clk(aclk),
      .d({osc_input_pin, pll_mult_clk, pll_freerun_clk, pll_lock_valid}),
      .q({osc_s, mult_s, free_s, lock_s})
   );

   // straps follow the pins while reset is held, frozen after
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         straps_r <= strap_s;
      end
   end

   // strap decode: only 011 and 001 bypass the pll
   always_comb begin
      mode = scg_pkg::SCG_MODE_PLL;
      halves = `SCG_HALVES_NONE;
      unique case (straps_r)
         `SCG_STRAP_X4: halves = `SCG_HALVES_X4;
         `SCG_STRAP_X2: halves = `SCG_HALVES_X2;
         `SCG_STRAP_X3: halves = `SCG_HALVES_X3;
         `SCG_STRAP_X5: halves = `SCG_HALVES_X5;
         `SCG_STRAP_X1P5: halves = `SCG_HALVES_X1P5;
         `SCG_STRAP_X2P5: halves = `SCG_HALVES_X2P5;
         `SCG_STRAP_DIRECT: mode = scg_pkg::SCG_MODE_DIRECT;
         `SCG_STRAP_PRESC: mode = scg_pkg::SCG_MODE_PRESC;
      endcase
   end

   // edge history of the resampled clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_d_r <= osc_s; // pin level, so no false edge after reset
         free_d_r <= free_s;
      end else begin
         osc_d_r <= osc_s;
         free_d_r <= free_s;
      end
   end
   assign osc_edge = osc_s ^ osc_d_r;
   assign osc_rise = osc_s & ~osc_d_r;
   assign free_tick = free_s & ~free_d_r;

   // pll core controls: multiply only in pll mode, free-run always
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pll_enable_r <= 1'b0;
         pll_mult_halves_r <= `SCG_HALVES_NONE;
      end else begin
         pll_enable_r <= (mode == scg_pkg::SCG_MODE_PLL);
         pll_mult_halves_r <= halves;
      end
   end

   // hold cpu clock low until the free-running clock has settled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_cnt_r <= '0;
         started_r <= 1'b0;
      end else if (!started_r) begin
         start_cnt_r <= start_cnt_r + 1'b1;
         started_r <= (start_cnt_r == FREERUN_CYC - 1'b1);
      end
   end

   // lock supervision: lock must arrive in time, then hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_cnt_r <= '0;
         lock_late_r <= 1'b0;
         was_locked_r <= 1'b0;
      end else if (started_r && mode == scg_pkg::SCG_MODE_PLL) begin
         if (lock_s) begin
            was_locked_r <= 1'b1;
         end else if (!was_locked_r && !lock_late_r) begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
            lock_late_r <= (lock_cnt_r == LOCK_CYC - 1'b1);
         end
      end
   end
   // a level event, so the flag keeps returning after each clear
   assign lock_loss_evt = (mode == scg_pkg::SCG_MODE_PLL) && !lock_s &&
      (was_locked_r || lock_late_r);

   // watchdog is armed only when the pll is bypassed
   scg_osc_watchdog u_wd (
      .clk(aclk),
      .rst_n(aresetn),
      .enable(started_r && mode != scg_pkg::SCG_MODE_PLL),
      .freerun_tick(free_tick),
      .osc_edge(osc_edge),
      .fail_r(wd_fail_r)
   );

   // prescaler flips on each oscillator rise: one phase per period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_r <= 1'b0;
      end else if (osc_rise) begin
         presc_r <= ~presc_r;
      end
   end

   // cpu clock mux; resampling adds at most one aclk of edge jitter,
   // small against the cpu period only while aclk is far faster
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_clk_r <= 1'b0;
         fallback_active_r <= 1'b0;
      end else if (!started_r) begin
         cpu_clk_r <= 1'b0;
      end else if (wd_fail_r) begin
         cpu_clk_r <= free_s;
         fallback_active_r <= 1'b1;
      end else begin
         unique case (mode)
            scg_pkg::SCG_MODE_PLL: begin
               cpu_clk_r <= lock_s ? mult_s : free_s;
               fallback_active_r <= !lock_s;
            end
            scg_pkg::SCG_MODE_DIRECT: begin
               cpu_clk_r <= osc_s;
               fallback_active_r <= 1'b0;
            end
            scg_pkg::SCG_MODE_PRESC: begin
               cpu_clk_r <= presc_r;
               fallback_active_r <= 1'b0;
            end
            default: begin
               cpu_clk_r <= 1'b0;
               fallback_active_r <= 1'b0;
            end
         endcase
      end
   end

   // axi handshakes
   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign b_hs = s_axi_bvalid & s_axi_bready;
   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign r_hs = s_axi_rvalid & s_axi_rready;
   assign wr_do = aw_got_r & w_got_r & ~s_axi_bvalid;

   // write address and data taken in either order, held to response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (aw_hs) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         aw_got_r <= b_hs ? 1'b0 : (aw_got_r | aw_hs);
         w_got_r <= b_hs ? 1'b0 : (w_got_r | w_hs);
         s_axi_awready <= b_hs | ~(aw_got_r | aw_hs);
         s_axi_wready <= b_hs | ~(w_got_r | w_hs);
      end
   end

   // write response; only the mask register takes writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SCG_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_r == `SCG_OFS_MASK ||
            awaddr_r == `SCG_OFS_STATUS || awaddr_r == `SCG_OFS_INFO) ?
            `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
      end else if (b_hs) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // mask register, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= `SCG_MASK_RST;
      end else if (wr_do && awaddr_r == `SCG_OFS_MASK && wstrb_r[0]) begin
         mask_r <= wdata_r[`SCG_IRQ_W-1:0];
      end
   end

   // read channel, one read in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `SCG_RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SCG_RESP_OKAY;
         unique case (s_axi_araddr)
            `SCG_OFS_STATUS: s_axi_rdata <= {30'h0, status_r};
            `SCG_OFS_MASK: s_axi_rdata <= {30'h0, mask_r};
            `SCG_OFS_INFO: s_axi_rdata <= {26'h0, started_r,
               fallback_active_r, lock_s, straps_r};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `SCG_RESP_SLVERR;
            end
         endcase
      end else if (r_hs || !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // sticky status; a set in the clearing cycle survives
   assign status_set = {wd_fail_r & ~status_r[`SCG_BIT_OSC_FAIL] &
      ~fallback_active_r, lock_loss_evt};
   assign status_clr = (ar_hs && s_axi_araddr == `SCG_OFS_STATUS) ?
      {`SCG_IRQ_W{1'b1}} : {`SCG_IRQ_W{1'b0}};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~status_clr) | status_set;
      end
   end

   // level interrupt from unmasked status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & mask_r);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_STRAP_HOLD: assert property ($stable(straps_r))
      else $error("straps changed outside reset");
   AST_DIRECT_FOLLOW: assert property (started_r && !wd_fail_r &&
      mode == scg_pkg::SCG_MODE_DIRECT |=> cpu_clk_r == $past(osc_s))
      else $error("direct clock does not follow oscillator");
   AST_PRESC_PHASE: assert property (aresetn && osc_rise |=>
      presc_r != $past(presc_r))
      else $error("prescaler missed oscillator rise");
   AST_PRESC_HOLD: assert property (!osc_rise |=> $stable(presc_r))
      else $error("prescaler toggled without oscillator rise");
   AST_FAILOVER: assert property (started_r && wd_fail_r |=>
      cpu_clk_r == $past(free_s) && fallback_active_r)
      else $error("cpu clock not on free-run after failure");
   AST_LOCK_LOSS_SET: assert property (lock_loss_evt |=>
      status_r[`SCG_BIT_LOCK_LOSS])
      else $error("lock loss flag not set");
   AST_PLL_FALLBACK: assert property (started_r && !wd_fail_r &&
      mode == scg_pkg::SCG_MODE_PLL && !lock_s |=> cpu_clk_r == $past(free_s))
      else $error("pll mode not on free-run without lock");
   // gated by reset so the release edge, still resetting, is not judged
   AST_FACTOR: assert property (aresetn &&
      straps_r == `SCG_STRAP_X5 |=> pll_mult_halves_r == `SCG_HALVES_X5)
      else $error("wrong multiply factor");
   AST_START_LOW: assert property (!started_r |=> !cpu_clk_r)
      else $error("cpu clock ran before settle time");
   AST_IRQ: assert property (|(status_r & mask_r) |=> irq_r)
      else $error("interrupt missing for unmasked status");
   COV_FAILOVER: cover property (!wd_fail_r ##1 wd_fail_r);
   COV_LOCK_LOSS: cover property (was_locked_r && lock_s ##1 !lock_s);
   COV_STATUS_READ: cover property (ar_hs &&
      s_axi_araddr == `SCG_OFS_STATUS && status_r != '0);
endmodule
`default_nettype wire

// ---- test/scg_clk_src_model.sv ----
// Purpose: behavioural crystal and pll core in front of the generator
// Assumes: aclk rises 5 ns past each multiple of 10 ns
// Notes: a stopped crystal holds its last level, as a dead one does
`timescale 1ns/1ps
`default_nettype none
module scg_clk_src_model #(
   parameter int OSC_HI_NS = 60,
   parameter int OSC_LO_NS = 140,
   parameter int FREE_HALF_NS = 40,
   parameter int MULT_HALF_NS = 30,
   parameter int LOCK_NS = 300
) (
   input wire logic osc_run,
   input wire logic lock_ok,
   output logic osc_input_pin,
   output logic pll_freerun_clk,
   output logic pll_mult_clk,
   output logic pll_lock_valid
);
   int good_ns; // time the input has been usable
   // crystal, clear of the aclk edges so sampling is exact
   initial begin
      osc_input_pin = 1'b0;
      #3;
      forever begin
         if (osc_run) begin
            osc_input_pin = 1'b1;
            #(OSC_HI_NS);
            osc_input_pin = 1'b0;
            #(OSC_LO_NS);
         end else begin
            #10;
         end
      end
   end
   // free-running source never stops, crystal or not
   initial begin
      pll_freerun_clk = 1'b0;
      #7;
      forever #(FREE_HALF_NS) pll_freerun_clk = ~pll_freerun_clk;
   end
   // multiplied output
   initial begin
      pll_mult_clk = 1'b0;
      #4;
      forever #(MULT_HALF_NS) pll_mult_clk = ~pll_mult_clk;
   end
   // lock follows a settled input; lock_ok lets the bench upset it
   initial begin
      good_ns = 0;
      pll_lock_valid = 1'b0;
      #1;
      forever begin
         good_ns = (osc_run && lock_ok) ? good_ns + 10 : 0;
         pll_lock_valid = (good_ns >= LOCK_NS);
         #10;
      end
   end
endmodule
`default_nettype wire

// ---- test/system_clock_generator_tb_top.sv ----
// Purpose: self-checking bench for the clock generator
// Assumes: shortened start-up and lock counts
// Notes: clock phases measured in aclk cycles
`include "scg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module system_clock_generator_tb_top;
   localparam int FREE_CYC = 20; // shortened start-up wait
   logic aclk;
   logic aresetn;
   logic [2:0] straps;
   logic osc_run; // crystal running
   logic lock_ok; // input judged stable
   logic osc, pfree, pmult, plock;
   logic cpu_clk, pll_en, fb, irq;
   logic [3:0] halves;
   logic [3:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   int fails, checks, cyc, h, l;
   // expected factor in halves, indexed by strap code
   logic [3:0] hv [8] = '{`SCG_HALVES_X2P5, `SCG_HALVES_NONE,
      `SCG_HALVES_X1P5, `SCG_HALVES_NONE, `SCG_HALVES_X5,
      `SCG_HALVES_X3, `SCG_HALVES_X2, `SCG_HALVES_X4};

   scg_clk_src_model src_u (.osc_run(osc_run), .lock_ok(lock_ok),
      .osc_input_pin(osc), .pll_freerun_clk(pfree),
      .pll_mult_clk(pmult), .pll_lock_valid(plock));

   scg_top #(.P_FREERUN_CYC(FREE_CYC), .P_LOCK_CYC(50)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .clock_config_straps(straps),
      .osc_input_pin(osc), .pll_mult_clk(pmult), .pll_freerun_clk(pfree),
      .pll_lock_valid(plock), .cpu_clk_r(cpu_clk), .pll_enable_r(pll_en),
      .pll_mult_halves_r(halves), .fallback_active_r(fb), .irq_r(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // 100 MHz clock
   always #5 aclk = ~aclk;

   // hang guard, well above the expected run length
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: %s seen %h expected %h", $time, what,
            seen, exp);
      end
   endtask

   // one write; address and data offered together, released when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
      bit done;
      done = 0;
      r = 2'h3;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
      @(posedge aclk); // bready stays low over one edge
   endtask

   // one read; rready held until data seen
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      bit done;
      done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
      @(posedge aclk); // rready stays low over one edge
   endtask

   // reset with a strap pattern, then wait out the start-up time
   task automatic do_reset(input logic [2:0] s);
      aresetn <= 1'b0;
      straps <= s;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (FREE_CYC + 30) @(posedge aclk);
   endtask

   // high and low length of one cpu clock period, in aclk cycles
   task automatic phase(output int hi, output int lo);
      int n;
      for (n = 0; n < 300 && cpu_clk !== 1'b0; n++) @(posedge aclk);
      for (n = 0; n < 300 && cpu_clk !== 1'b1; n++) @(posedge aclk);
      for (hi = 0; hi < 300 && cpu_clk === 1'b1; hi++) @(posedge aclk);
      for (lo = 0; lo < 300 && cpu_clk === 1'b0; lo++) @(posedge aclk);
   endtask

   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      aclk = 0;
      aresetn = 0;
      straps = 3'h7;
      osc_run = 1;
      lock_ok = 1;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      {fails, checks, cyc} = '0;
      // every strap code; pins changed after reset must not matter
      for (int c = 0; c < 8; c++) begin
         do_reset(c[2:0]);
         straps <= ~c[2:0];
         repeat (4) @(posedge aclk);
         chk(halves, hv[c], "multiply factor");
         chk(pll_en, hv[c] != 4'h0, "pll enable");
         chk(fb, 1'b0, "fallback after reset");
         axi_rd(`SCG_OFS_INFO, rd, rsp);
         chk(rd[2:0], c[2:0], "latched straps");
      end
      $display("test strap modes done");
      // lock loss in pll mode, masked and unmasked
      do_reset(3'h7);
      axi_wr(`SCG_OFS_MASK, 32'h1, rsp);
      lock_ok <= 1'b0;
      for (int n = 0; n < 40 && irq !== 1'b1; n++) @(posedge aclk);
      chk(irq, 1'b1, "lock loss irq");
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      chk(rd, 32'h1, "lock loss status");
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      chk(rd, 32'h1, "lock loss raised again");
      phase(h, l);
      chk(h + l, 8, "free-run period in lock loss");
      axi_wr(`SCG_OFS_MASK, 32'h0, rsp);
      repeat (4) @(posedge aclk);
      chk(irq, 1'b0, "masked irq");
      lock_ok <= 1'b1;
      repeat (60) @(posedge aclk);
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      chk(rd, 32'h0, "status clear once locked");
      // lock never arrives: flagged once the lock wait runs out
      lock_ok <= 1'b0;
      do_reset(3'h7);
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      chk(rd, 32'h0, "no flag while lock awaited");
      repeat (30) @(posedge aclk);
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      chk(rd, 32'h1, "lock overdue flag");
      lock_ok <= 1'b1;
      $display("test lock loss done");
      // direct drive, then a dead crystal
      do_reset(3'h3);
      phase(h, l);
      chk(h, 6, "direct high time");
      chk(l, 14, "direct low time");
      repeat (300) @(posedge aclk);
      chk(fb, 1'b0, "watchdog quiet with edges");
      axi_wr(`SCG_OFS_MASK, 32'h2, rsp);
      chk(rsp, `SCG_RESP_OKAY, "mask write response");
      osc_run <= 1'b0;
      for (int n = 0; n < 400 && fb !== 1'b1; n++) @(posedge aclk);
      chk(fb, 1'b1, "switch to free-run");
      for (int n = 0; n < 10 && irq !== 1'b1; n++) @(posedge aclk);
      chk(irq, 1'b1, "osc fail irq");
      phase(h, l);
      chk({h[7:0], l[7:0]}, 16'h0404, "free-run phases");
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      chk(rd, 32'h2, "osc fail status");
      axi_rd(`SCG_OFS_STATUS, rd, rsp);
      chk(rd, 32'h0, "status cleared by read");
      osc_run <= 1'b1;
      repeat (100) @(posedge aclk);
      chk(fb, 1'b1, "fallback holds");
      phase(h, l);
      chk({h[7:0], l[7:0]}, 16'h0404, "still free-run");
      $display("test direct and watchdog done");
      // prescaler and unmapped places
      do_reset(3'h1);
      repeat (300) @(posedge aclk);
      phase(h, l);
      chk({h[7:0], l[7:0]}, 16'h1414, "prescaler phases");
      chk(fb, 1'b0, "no failover in prescaler");
      axi_rd(4'hC, rd, rsp);
      chk(rd, 32'h0, "unmapped read data");
      chk(rsp, `SCG_RESP_SLVERR, "unmapped read response");
      axi_wr(4'hC, 32'h3, rsp);
      chk(rsp, `SCG_RESP_SLVERR, "unmapped write");
      $display("test prescaler done");
      end_of_test();
   end
endmodule
`default_nettype wire
